/* File: rtl/dma_seq_defines.vh */
// offsets, field positions, reset values and codes of the channel sequencer
`ifndef DMA_SEQ_DEFINES_VH
`define DMA_SEQ_DEFINES_VH

// ****************************************************************
// descriptor word indices (channel block of 16 words, stride 0x40)
// ****************************************************************
`define W_SRC_PTR      3'h0
`define W_STEP         3'h1
`define W_TRANSFER_ATTRIBUTES         3'h2
`define W_MINOR_BYTES  3'h3
`define W_SRC_ADJ      3'h4
`define W_DST_PTR      3'h5
`define W_DST_ADJ      3'h6
`define W_ITER         3'h7
`define W_CSR          4'h8

// ****************************************************************
// global register byte addresses
// ****************************************************************
`define REG_HW_REQ_EN  12'h0400
`define REG_IRQ_FLAGS  12'h0404
`define REG_CTRL       12'h0408
`define REG_STATUS     12'h040C

// ****************************************************************
// field positions
// ****************************************************************
`define CSR_START      0
`define CSR_IRQ_EN     1
`define CSR_PREEMPT    2
`define CSR_ACTIVE     6
`define CSR_DONE       7
`define TRANSFER_ATTRIBUTES_DESTINATION_ACCESS_WIDTH_LSB 0
`define TRANSFER_ATTRIBUTES_DMOD_LSB  3
`define TRANSFER_ATTRIBUTES_SOURCE_ACCESS_WIDTH_LSB 8
`define TRANSFER_ATTRIBUTES_SMOD_LSB  11
`define CTRL_RR        0

// ****************************************************************
// reset values and access width codes
// ****************************************************************
`define RST_WORD       32'h0000_0000
`define SZ_BYTE        3'h0
`define SZ_LONG        3'h2

`endif

/* File: rtl/dma_channel_transfer_sequencer.v */
// channel transfer sequencer: descriptor store, arbiter, minor/major loops
`include "dma_seq_defines.vh"
`default_nettype none

module dma_channel_transfer_sequencer #(
	parameter CW = 2                        // channel index width
) (
	input  wire                ref_clk,     // system clock
	input  wire                reset_n,     // async reset, active low
	input  wire                psel,        // apb select
	input  wire                penable,     // apb access phase
	input  wire                pwrite,      // apb write
	input  wire [11:0]         paddr,       // apb byte address
	input  wire [31:0]         pwdata,      // apb write data
	output reg  [31:0]         prdata,      // apb read data
	output wire                pready,      // apb ready, zero wait
	output wire                pslverr,     // unmapped access
	input  wire [(1<<CW)-1:0]  hw_req,      // peripheral requests
	output reg  [(1<<CW)-1:0]  hw_ack,      // request taken pulse
	output reg                 mem_req,     // system bus request
	output reg                 mem_we,      // system bus write
	output reg  [31:0]         mem_addr,    // system bus address
	output reg  [1:0]          mem_size,    // access width code
	output reg  [31:0]         mem_wdata,   // write data, low lanes
	input  wire                mem_ack,     // access complete
	input  wire [31:0]         mem_rdata,   // read data, low lanes
	output wire [(1<<CW)-1:0]  channel_irq  // per channel interrupt
);

	localparam CH = 1 << CW;
	localparam ST_IDLE = 3'd0;
	localparam ST_LOAD = 3'd1;
	localparam ST_XFER = 3'd2;
	localparam ST_WAIT = 3'd3;
	localparam ST_WB   = 3'd4;

	// ****************************************************************
	// storage
	// ****************************************************************
	reg  [31:0]    desc_q [0:CH*8-1];
	reg  [CH-1:0]  start_q;
	reg  [CH-1:0]  irqen_q;
	reg  [CH-1:0]  preempt_q;
	reg  [CH-1:0]  active_q;
	reg  [CH-1:0]  done_q;
	reg  [CH-1:0]  erq_q;
	reg  [CH-1:0]  irqf_q;
	reg            rr_mode_q;
	reg  [CW-1:0]  rr_q;
	reg  [2:0]     state_q;
	reg  [CW-1:0]  cur_q;
	reg  [31:0]    src_q;
	reg  [31:0]    dst_q;
	reg  [31:0]    nb_q;
	reg  [31:0]    buf_q;
	reg  [2:0]     bcnt_q;
	reg            sus_v_q;
	reg  [CW-1:0]  sus_ch_q;
	reg  [31:0]    sus_src_q;
	reg  [31:0]    sus_dst_q;
	reg  [31:0]    sus_nb_q;
	reg  [31:0]    sus_buf_q;
	reg  [2:0]     sus_bcnt_q;
	integer        i;
	integer        j;

	// modulo wrap: for a nonzero field only the low field bits may move; zero adds without wrap
	function [31:0] wrap_add;
		input [31:0] a;
		input [31:0] off;
		input [4:0]  m;
		reg   [31:0] s;
		reg   [31:0] k;
		begin
			s = a + off;
			k = (32'h0000_0001 << m) - 32'h0000_0001;
			wrap_add = (m == 5'h00) ? s : ((a & ~k) | (s & k));
		end
	endfunction

	// ****************************************************************
	// current descriptor fields
	// ****************************************************************
	wire [31:0] stp  = desc_q[{cur_q, `W_STEP}];
	wire [31:0] att  = desc_q[{cur_q, `W_TRANSFER_ATTRIBUTES}];
	wire [31:0] itr  = desc_q[{cur_q, `W_ITER}];
	wire [31:0] source_step = {{16{stp[15]}}, stp[15:0]};
	wire [31:0] destination_step = {{16{stp[31]}}, stp[31:16]};
	wire [2:0]  ssz  = att[`TRANSFER_ATTRIBUTES_SOURCE_ACCESS_WIDTH_LSB+2:`TRANSFER_ATTRIBUTES_SOURCE_ACCESS_WIDTH_LSB];
	wire [2:0]  dsz  = att[`TRANSFER_ATTRIBUTES_DESTINATION_ACCESS_WIDTH_LSB+2:`TRANSFER_ATTRIBUTES_DESTINATION_ACCESS_WIDTH_LSB];
	wire [4:0]  smod = att[`TRANSFER_ATTRIBUTES_SMOD_LSB+4:`TRANSFER_ATTRIBUTES_SMOD_LSB];
	wire [4:0]  dmod = att[`TRANSFER_ATTRIBUTES_DMOD_LSB+4:`TRANSFER_ATTRIBUTES_DMOD_LSB];
	wire [2:0]  sbytes = 3'd1 << ssz[1:0];
	wire [2:0]  dbytes = 3'd1 << dsz[1:0];
	wire [31:0] rmask = (ssz == `SZ_BYTE) ? 32'h0000_00FF :
		((ssz == `SZ_LONG) ? 32'hFFFF_FFFF : 32'h0000_FFFF);

	// ****************************************************************
	// arbitration
	// ****************************************************************
	reg  [CH-1:0] pend;
	reg  [CW-1:0] win;
	reg  [CW-1:0] idx;
	reg           win_v;

	// pending requests; running or suspended channels are excluded
	always @*
	begin
		pend = (start_q | (hw_req & erq_q)) & ~active_q;
		win = {CW{1'b0}};
		win_v = 1'b0;
		idx = rr_mode_q ? rr_q : {CW{1'b0}};
		for (j = 0; j < CH; j = j + 1)
		begin
			if (rr_mode_q)
			begin
				if (!win_v && pend[idx])
				begin
					win = idx;
					win_v = 1'b1;
				end
				idx = idx - 1'b1;
			end
			else
			begin
				if (pend[idx])
				begin
					win = idx;
					win_v = 1'b1;
				end
				idx = idx + 1'b1;
			end
		end
	end

	// preemption at an access boundary, fixed priority, one level deep
	wire preempt = (state_q == ST_XFER) && !rr_mode_q && preempt_q[cur_q]
		&& !sus_v_q && win_v && (win > cur_q);
	wire launch = win_v && ((state_q == ST_IDLE) || preempt);
	wire [CH-1:0] win_oh = {{(CH-1){1'b0}}, 1'b1} << win;
	wire [CH-1:0] cur_oh = {{(CH-1){1'b0}}, 1'b1} << cur_q;

	// ****************************************************************
	// register bus decode
	// ****************************************************************
	wire [CW-1:0]  a_ch = paddr[CW+5:6];
	wire [3:0]     a_wd = paddr[5:2];
	wire [CW+2:0]  a_ix = {a_ch, paddr[4:2]};
	wire ch_hit = (paddr[11:CW+6] == 0) && (a_wd <= `W_CSR)
		&& (paddr[1:0] == 2'b00);
	wire gl_hit = (paddr == `REG_HW_REQ_EN) || (paddr == `REG_IRQ_FLAGS)
		|| (paddr == `REG_CTRL) || (paddr == `REG_STATUS);
	wire hit = ch_hit || gl_hit;
	wire wr = psel && penable && pwrite && hit;
	wire live = active_q[a_ch] && (a_ch == cur_q) && (state_q != ST_IDLE)
		&& (state_q != ST_LOAD);

	assign pready = 1'b1;
	assign pslverr = psel && penable && !hit;
	assign channel_irq = irqf_q & irqen_q;

	// read data captured in the setup phase; no request line is readable
	always @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
			prdata <= `RST_WORD;
		else if (psel && !penable && !pwrite)
		begin
			if (ch_hit && a_wd == `W_CSR)
				prdata <= {24'h00_0000, done_q[a_ch], active_q[a_ch], 3'b000,
					preempt_q[a_ch], irqen_q[a_ch], start_q[a_ch]};
			else if (ch_hit && live && a_wd[2:0] == `W_SRC_PTR)
				prdata <= src_q;
			else if (ch_hit && live && a_wd[2:0] == `W_DST_PTR)
				prdata <= dst_q;
			else if (ch_hit && live && a_wd[2:0] == `W_MINOR_BYTES)
				prdata <= nb_q;
			else if (ch_hit)
				prdata <= desc_q[a_ix];
			else if (paddr == `REG_HW_REQ_EN)
				prdata <= {{(32-CH){1'b0}}, erq_q};
			else if (paddr == `REG_IRQ_FLAGS)
				prdata <= {{(32-CH){1'b0}}, irqf_q};
			else if (paddr == `REG_CTRL)
				prdata <= {31'h0000_0000, rr_mode_q};
			else if (paddr == `REG_STATUS)
				prdata <= {23'h00_0000, sus_v_q, 3'b000,
					(state_q != ST_IDLE), {(4-CW){1'b0}}, cur_q};
			else
				prdata <= `RST_WORD;
		end
	end

	// ****************************************************************
	// engine and register file
	// ****************************************************************
	// launch clears before the bus write so a software set wins;
	// completion sets after it so a hardware set wins
	always @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			for (i = 0; i < CH*8; i = i + 1)
				desc_q[i] <= `RST_WORD;
			start_q <= {CH{1'b0}};
			irqen_q <= {CH{1'b0}};
			preempt_q <= {CH{1'b0}};
			active_q <= {CH{1'b0}};
			done_q <= {CH{1'b0}};
			erq_q <= {CH{1'b0}};
			irqf_q <= {CH{1'b0}};
			rr_mode_q <= 1'b0;
			rr_q <= {CW{1'b1}};
			state_q <= ST_IDLE;
			cur_q <= {CW{1'b0}};
			src_q <= `RST_WORD;
			dst_q <= `RST_WORD;
			nb_q <= `RST_WORD;
			buf_q <= `RST_WORD;
			bcnt_q <= 3'd0;
			sus_v_q <= 1'b0;
			sus_ch_q <= {CW{1'b0}};
			sus_src_q <= `RST_WORD;
			sus_dst_q <= `RST_WORD;
			sus_nb_q <= `RST_WORD;
			sus_buf_q <= `RST_WORD;
			sus_bcnt_q <= 3'd0;
			hw_ack <= {CH{1'b0}};
			mem_req <= 1'b0;
			mem_we <= 1'b0;
			mem_addr <= `RST_WORD;
			mem_size <= 2'b00;
			mem_wdata <= `RST_WORD;
		end
		else
		begin
			hw_ack <= {CH{1'b0}};
			// begin execution of the selected channel
			if (launch)
			begin
				if (preempt)
				begin
					sus_v_q <= 1'b1;
					sus_ch_q <= cur_q;
					sus_src_q <= src_q;
					sus_dst_q <= dst_q;
					sus_nb_q <= nb_q;
					sus_buf_q <= buf_q;
					sus_bcnt_q <= bcnt_q;
				end
				start_q[win] <= 1'b0;
				done_q[win] <= 1'b0;
				active_q[win] <= 1'b1;
				hw_ack <= win_oh & hw_req & erq_q;
				rr_q <= win - 1'b1;
				cur_q <= win;
				state_q <= ST_LOAD;
			end
			// software writes
			if (wr && ch_hit && a_wd == `W_CSR)
			begin
				start_q[a_ch] <= pwdata[`CSR_START];
				irqen_q[a_ch] <= pwdata[`CSR_IRQ_EN];
				preempt_q[a_ch] <= pwdata[`CSR_PREEMPT];
				if (!pwdata[`CSR_DONE])
					done_q[a_ch] <= 1'b0;
			end
			else if (wr && ch_hit)
				desc_q[a_ix] <= pwdata;
			else if (wr && paddr == `REG_HW_REQ_EN)
				erq_q <= pwdata[CH-1:0];
			else if (wr && paddr == `REG_IRQ_FLAGS)
				irqf_q <= irqf_q & ~pwdata[CH-1:0];
			else if (wr && paddr == `REG_CTRL)
				rr_mode_q <= pwdata[`CTRL_RR];
			// transfer sequencing
			case (state_q)
				ST_LOAD:
				begin
					src_q <= desc_q[{cur_q, `W_SRC_PTR}];
					dst_q <= desc_q[{cur_q, `W_DST_PTR}];
					nb_q <= desc_q[{cur_q, `W_MINOR_BYTES}];
					buf_q <= `RST_WORD;
					bcnt_q <= 3'd0;
					state_q <= ST_XFER;
				end
				ST_XFER:
				begin
					if (preempt)
						state_q <= ST_LOAD;
					else if (bcnt_q >= dbytes)
					begin
						mem_req <= 1'b1;
						mem_we <= 1'b1;
						mem_addr <= dst_q;
						mem_size <= dsz[1:0];
						mem_wdata <= buf_q;
						state_q <= ST_WAIT;
					end
					else if (nb_q > {29'h0000_0000, bcnt_q})
					begin
						mem_req <= 1'b1;
						mem_we <= 1'b0;
						mem_addr <= src_q;
						mem_size <= ssz[1:0];
						state_q <= ST_WAIT;
					end
					else
						state_q <= ST_WB;
				end
				ST_WAIT:
				begin
					if (mem_ack && mem_we)
					begin
						mem_req <= 1'b0;
						buf_q <= buf_q >> {dbytes, 3'b000};
						bcnt_q <= bcnt_q - dbytes;
						dst_q <= wrap_add(dst_q, destination_step, dmod);
						nb_q <= nb_q - {29'h0000_0000, dbytes};
						state_q <= ST_XFER;
					end
					else if (mem_ack)
					begin
						mem_req <= 1'b0;
						buf_q <= buf_q | ((mem_rdata & rmask) << {bcnt_q, 3'b000});
						bcnt_q <= bcnt_q + sbytes;
						src_q <= wrap_add(src_q, source_step, smod);
						state_q <= ST_XFER;
					end
				end
				ST_WB:
				begin
					if (itr[15:0] <= 16'h0001)
					begin
						desc_q[{cur_q, `W_SRC_PTR}] <=
							src_q + desc_q[{cur_q, `W_SRC_ADJ}];
						desc_q[{cur_q, `W_DST_PTR}] <=
							dst_q + desc_q[{cur_q, `W_DST_ADJ}];
						desc_q[{cur_q, `W_ITER}] <= {itr[31:16], itr[31:16]};
						done_q[cur_q] <= 1'b1;
						irqf_q[cur_q] <= 1'b1;
					end
					else
					begin
						desc_q[{cur_q, `W_SRC_PTR}] <= src_q;
						desc_q[{cur_q, `W_DST_PTR}] <= dst_q;
						desc_q[{cur_q, `W_ITER}] <=
							{itr[31:16], itr[15:0] - 16'h0001};
					end
					active_q[cur_q] <= 1'b0;
					if (sus_v_q)
					begin
						sus_v_q <= 1'b0;
						cur_q <= sus_ch_q;
						src_q <= sus_src_q;
						dst_q <= sus_dst_q;
						nb_q <= sus_nb_q;
						buf_q <= sus_buf_q;
						bcnt_q <= sus_bcnt_q;
						state_q <= ST_XFER;
					end
					else
						state_q <= ST_IDLE;
				end
				default:
				begin
					if (!launch)
						state_q <= ST_IDLE;
				end
			endcase
		end
	end

endmodule // dma_channel_transfer_sequencer

`default_nettype wire

/* File: test/dma_seq_monitor.sv */
// port checker for the channel transfer sequencer
`default_nettype none
module dma_seq_monitor #(
	parameter CW = 2 // channel index width
) (
	input wire logic               ref_clk,    // clock
	input wire logic               reset_n,    // reset, active low
	input wire logic               psel,       // apb select
	input wire logic               penable,    // apb access
	input wire logic               pwrite,     // apb write
	input wire logic [(1<<CW)-1:0] hw_req,     // requests
	input wire logic [(1<<CW)-1:0] hw_ack,     // request taken
	input wire logic               mem_req,    // bus request
	input wire logic               mem_we,     // bus write
	input wire logic [31:0]        mem_addr,   // bus address
	input wire logic [1:0]         mem_size,   // width code
	input wire logic [31:0]        mem_wdata,  // write data
	input wire logic               mem_ack,    // bus done
	input wire logic [(1<<CW)-1:0] channel_irq // interrupts
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!reset_n);
	// ****************************************************************
	// bus steps
	// ****************************************************************
	sequence s_wait;
		mem_req && !mem_ack;
	endsequence
	sequence s_acked;
		mem_req && mem_ack;
	endsequence
	sequence s_quiet2;
		!mem_req ##1 !mem_req;
	endsequence
	req_hold_a: assert property (s_wait |=> mem_req &&
		$stable(mem_addr) && $stable(mem_we) && $stable(mem_size)
		&& $stable(mem_wdata)) else $error("bus request changed early");
	req_drop_a: assert property (s_acked |=> !mem_req)
		else $error("bus request held after ack");
	size_code_a: assert property (mem_req |-> mem_size != 2'h3)
		else $error("bad access width");
	load_first_a: assert property (|hw_ack |-> s_quiet2)
		else $error("bus access before descriptor load");
	ack_pulse_a: assert property (|hw_ack |=> hw_ack == '0)
		else $error("request ack longer than a cycle");
	ack_cause_a: assert property (|hw_ack |->
		(hw_ack & ~$past(hw_req)) == '0) else $error("ack without request");
	ack_single_a: assert property ($onehot0(hw_ack))
		else $error("two channels selected");
	irq_sticky_a: assert property (|($past(channel_irq) & ~channel_irq)
		|-> $past(psel && penable && pwrite))
		else $error("interrupt dropped without a write");
endmodule // dma_seq_monitor
bind dma_channel_transfer_sequencer dma_seq_monitor #(.CW(CW)) mon_i (
	.ref_clk(ref_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
	.pwrite(pwrite), .hw_req(hw_req), .hw_ack(hw_ack), .mem_req(mem_req),
	.mem_we(mem_we), .mem_addr(mem_addr), .mem_size(mem_size),
	.mem_wdata(mem_wdata), .mem_ack(mem_ack), .channel_irq(channel_irq));
`default_nettype wire

/* File: test/sys_mem_model.sv */
// system bus memory answering the sequencer
`default_nettype none
module sys_mem_model (
	input  wire logic        ref_clk,   // clock
	input  wire logic        mem_req,   // request
	input  wire logic        mem_we,    // write
	input  wire logic [31:0] mem_addr,  // address
	input  wire logic [1:0]  mem_size,  // width code
	input  wire logic [31:0] mem_wdata, // write data
	output var  logic        mem_ack,   // done pulse
	output var  logic [31:0] mem_rdata  // read data
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] wa [0:255];
	logic [31:0] wd [0:255];
	int          wn = 0;
	int          dly = 0;
	// fixed byte content of every address
	function automatic logic [7:0] mb(input logic [31:0] a);
		return a[7:0] ^ a[15:8] ^ 8'h5a;
	endfunction
	initial mem_ack = 1'b0;
	initial mem_rdata = 32'h0000_0000;
	// one ack per request after a random wait; idle data toggles
	always @(posedge ref_clk)
	begin
		mem_ack <= 1'b0;
		mem_rdata <= ~mem_rdata;
		if (mem_req && !mem_ack)
		begin
			if (dly != 0)
				dly <= dly - 1;
			else
			begin
				mem_ack <= 1'b1;
				dly <= $urandom % 4;
				mem_rdata <= {mb(mem_addr + 3), mb(mem_addr + 2),
					mb(mem_addr + 1), mb(mem_addr)};
				if (mem_we)
				begin
					wa[wn & 255] <= mem_addr;
					wd[wn & 255] <= (mem_size == 2'h0) ?
						{24'h00_0000, mem_wdata[7:0]} : mem_wdata;
					wn <= wn + 1;
				end
			end
		end
	end
endmodule // sys_mem_model
`default_nettype wire

/* File: test/test_dma_channel_transfer_sequencer.sv */
// self-checking bench for the channel transfer sequencer
`include "dma_seq_defines.vh"
`default_nettype none
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin errors++; \
	$display("ERROR %s exp %h got %h", n, e, s); end end
module test_dma_channel_transfer_sequencer;
	timeunit 1ns;
	timeprecision 1ps;
	logic        ref_clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, r;
	logic [3:0]  hw_req = 0;
	logic        e;
	wire  [31:0] prdata, mem_addr, mem_wdata, mem_rdata;
	wire         pready, pslverr, mem_req, mem_we, mem_ack;
	wire  [3:0]  hw_ack, channel_irq;
	wire  [1:0]  mem_size;
	int          errors = 0, check_count = 0;
	dma_channel_transfer_sequencer #(.CW(2)) dma_channel_transfer_sequencer_i (
		.ref_clk(ref_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .hw_req(hw_req), .hw_ack(hw_ack),
		.mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
		.mem_size(mem_size), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
		.mem_rdata(mem_rdata), .channel_irq(channel_irq));
	sys_mem_model sys_mem_model_i (.ref_clk(ref_clk), .mem_req(mem_req),
		.mem_we(mem_we), .mem_addr(mem_addr), .mem_size(mem_size),
		.mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
	initial
	begin
		forever #10 ref_clk = ~ref_clk;
	end
	task automatic end_of_test();
		if (errors == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic quit();
		errors++;
		end_of_test();
	endtask
	// apb transfer held until pready, released, then one idle edge
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] q, output logic x);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge ref_clk);
			n++;
		end
		while (pready !== 1'b1 && n < 50);
		if (n >= 50)
			quit();
		q = prdata;
		x = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge ref_clk);
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic        x;
		apb(1'b1, a, d, q, x);
	endtask
	// source address of read j under the wrap field
	function automatic logic [31:0] sa(logic [31:0] b, int j, int s, int m);
		logic [31:0] k;
		k = (m == 0) ? 32'hffff_ffff : (32'h0000_0001 << m) - 1;
		return (b & ~k) | ((b + j * s) & k);
	endfunction
	// byte i of the source stream
	function automatic logic [7:0] sb8(logic [31:0] b, int i, int s, int m);
		return sys_mem_model_i.mb(sa(b, i / s, s, m) + i % s);
	endfunction
	// program one channel and run all its minor loops
	task automatic xfer(int ch, logic hw, int it, int nb, int ss, int ds,
		int sm, logic ie);
		logic [31:0] sb, db, q, x;
		logic [11:0] o;
		int          sw, dw, w0, t, i;
		sw = 1 << ss;
		dw = 1 << ds;
		o = 12'(ch * 64);
		sb = ($urandom & 32'h0000_fff0) | 32'h0001_0000;
		db = ($urandom & 32'h0000_fff0) | 32'h0002_0000;
		wr(o, sb);
		wr(o + 12'h004, {16'(dw), 16'(sw)});
		wr(o + 12'h008, 32'((sm << 11) | (ss << 8) | ds));
		wr(o + 12'h00C, 32'(nb));
		wr(o + 12'h010, sb - sa(sb, nb * it / sw, sw, sm));
		wr(o + 12'h014, db);
		wr(o + 12'h018, 32'(-(nb * it)));
		wr(o + 12'h01C, {16'(it), 16'(it)});
		wr(`REG_HW_REQ_EN, hw ? 32'(1 << ch) : 32'h0000_0000);
		for (int k = 1; k <= it; k++)
		begin
			w0 = sys_mem_model_i.wn;
			if (hw)
			begin
				wr(o + 12'h020, {30'h0, ie, 1'b0});
				hw_req[ch] <= 1'b1;
				t = 0;
				while (hw_ack[ch] !== 1'b1 && t < 100)
				begin
					@(negedge ref_clk);
					t++;
				end
				@(posedge ref_clk);
				hw_req[ch] <= 1'b0;
				if (t >= 100)
					quit();
				apb(1'b0, o + 12'h020, 0, q, e);
				`CHK("launch bit", 1'b0, q[0])
			end
			else
				wr(o + 12'h020, {30'h0, ie, 1'b1});
			t = 0;
			do
			begin
				apb(1'b0, o + 12'h020, 0, q, e);
				t++;
			end
			while ((q[0] | q[6]) !== 1'b0 && t < 200);
			if (t >= 200)
				quit();
			`CHK("finished", k == it, q[7])
			`CHK("writes", nb / dw, sys_mem_model_i.wn - w0)
			for (int j = 0; j < nb / dw; j++)
			begin
				x = 0;
				for (int b = 0; b < dw; b++)
				begin
					i = (k - 1) * nb + j * dw + b;
					x = x | (32'(sb8(sb, i, sw, sm)) << (8 * b));
				end
				`CHK("dst addr", db + (k - 1) * nb + j * dw,
					sys_mem_model_i.wa[(w0 + j) & 255])
				`CHK("dst data", x, sys_mem_model_i.wd[(w0 + j) & 255])
			end
			apb(1'b0, o, 0, q, e);
			`CHK("src ptr", k < it ? sa(sb, k * nb / sw, sw, sm) : sb, q)
			apb(1'b0, o + 12'h014, 0, q, e);
			`CHK("dst ptr", k < it ? db + k * nb : db, q)
			apb(1'b0, o + 12'h01C, 0, q, e);
			`CHK("iter", {16'(it), 16'(k < it ? it - k : it)}, q)
		end
		`CHK("irq out", ie, channel_irq[ch])
		apb(1'b0, `REG_IRQ_FLAGS, 0, q, e);
		`CHK("irq flag", 1'b1, q[ch])
		wr(`REG_IRQ_FLAGS, 32'(1 << ch));
		`CHK("irq clear", 1'b0, channel_irq[ch])
	endtask
	// corner cases, random runs, then an unmapped word
	initial
	begin
		void'($urandom(15281));
		repeat (20) @(posedge ref_clk);
		reset_n <= 1'b1;
		@(posedge ref_clk);
		xfer(0, 1'b0, 1, 16, 0, 2, 0, 1'b1);
		xfer(1, 1'b1, 2, 16, 0, 2, 0, 1'b0);
		xfer(2, 1'b0, 3, 8, 2, 0, 4, 1'b1);
		xfer(2, 1'b1, 2, 4, 0, 0, 0, 1'b1);
		repeat (4)
			xfer($urandom % 4, $urandom % 2, 1 + $urandom % 3,
				4 * (1 + $urandom % 4), 2 * ($urandom % 2),
				2 * ($urandom % 2), 4 * ($urandom % 2), $urandom % 2);
		apb(1'b0, 12'h024, 32'h0000_0000, r, e);
		`CHK("unmapped err", 1'b1, e)
		`CHK("unmapped data", 32'h0000_0000, r)
		end_of_test();
	end
endmodule // test_dma_channel_transfer_sequencer
`default_nettype wire
